// file: verilog/awsc_area_wait_state_control.sv
`timescale 1ns/10ps
// Overview of operation
// - power-on reset loads 0xfffeefff, reserved bits zero
// - manual reset and standby leave the register contents untouched
// - one 32-bit read/write word holds first-wait and burst-pitch fields
// - area 6 first wait bits 31:29 coded 0,1,2,3,6,9,12,15; ready off at 000
// - area 6 burst pitch bits 28:26 binary waits; ready off at 000
// - area 5 first wait bits 25:23 same coding; ready off at 000
// - area 5 burst pitch bits 22:20 binary waits; ready off at 000
// - area 4 first wait bits 19:17 same coding; ready off at 000
// - burst pitch applies only to burst rom beyond the first access
// - reserved bits 16 and 12 always read zero
// - multiplexed interface areas use separate wait coding, not first-cycle one
// - ready pin sampled synchronously unless async enable bit set
module awsc_area_wait_state_control (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    manual_rst_n,
  input  wire logic                    standby,
  input  wire awsc_pkg::awsc_apb_req_t apb_req,
  output awsc_pkg::awsc_apb_rsp_t      apb_rsp,
  input  wire logic [2:0]              access_area,
  input  wire logic                    burst_rom,
  input  wire logic                    burst_later,
  input  wire logic [2:0]              mpx_area_enable,
  output awsc_pkg::awsc_wait_t         wait_sel,
  output logic                         ready_async
);
  import awsc_pkg::*;

  logic [31:0] area_wait_state_control;
  logic        ready_async_enable;
  logic [31:0] rdata;
  logic        sel_wait;
  logic        sel_async;
  logic        bus_wr;
  logic        bus_rd;
  awsc_wait_t  next_wait;
  logic [31:0] prdata_q;
  logic        unmapped_err;
  wire  [2:0]  area6_first_wait  = area_wait_state_control[AWSC_A6W_LSB +: 3];
  wire  [2:0]  area6_burst_pitch = area_wait_state_control[AWSC_A6B_LSB +: 3];
  wire  [2:0]  area5_first_wait  = area_wait_state_control[AWSC_A5W_LSB +: 3];
  wire  [2:0]  area5_burst_pitch = area_wait_state_control[AWSC_A5B_LSB +: 3];
  wire  [2:0]  area4_first_wait  = area_wait_state_control[AWSC_A4W_LSB +: 3];
  wire         access_phase      = apb_req.psel && apb_req.penable;

  // first-cycle coding shared by areas 4 to 6
  function automatic awsc_wait_t first_code(input logic [2:0] code);
    awsc_wait_t w;
    case (code)
      3'h0:    w.waits = 4'h0;
      3'h1:    w.waits = 4'h1;
      3'h2:    w.waits = 4'h2;
      3'h3:    w.waits = 4'h3;
      3'h4:    w.waits = 4'h6;
      3'h5:    w.waits = 4'h9;
      3'h6:    w.waits = 4'hc;
      default: w.waits = 4'hf;
    endcase
    w.ready_enable = (code != 3'h0);
    return w;
  endfunction : first_code

  // mpx coding: one extra address cycle folded into the count, ready always on
  function automatic awsc_wait_t mpx_code(input logic [2:0] code);
    awsc_wait_t w;
    w.waits        = {1'b0, code} + 4'h1;
    w.ready_enable = 1'b1;
    return w;
  endfunction : mpx_code

  function automatic awsc_wait_t pitch_code(input logic [2:0] code);
    awsc_wait_t w;
    w.waits        = {1'b0, code};
    w.ready_enable = (code != 3'h0);
    return w;
  endfunction : pitch_code

  assign sel_wait  = apb_req.paddr == AWSC_REG_OFFSET;
  assign sel_async = apb_req.paddr == AWSC_ASYNC_OFFSET;
  assign bus_wr    = access_phase && apb_req.pwrite;
  assign bus_rd    = access_phase && !apb_req.pwrite;
  assign rdata     = sel_wait  ? (area_wait_state_control & AWSC_WRITE_MASK) :
                     sel_async ? {31'h0, ready_async_enable} : 32'h0;

  // manual reset and standby are deliberately not looked at here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      area_wait_state_control <= AWSC_RESET_VALUE;
      ready_async_enable      <= 1'b0;
    end else if (bus_wr && sel_wait) begin
      area_wait_state_control <= apb_req.pwdata & AWSC_WRITE_MASK;
    end else if (bus_wr && sel_async) begin
      ready_async_enable      <= apb_req.pwdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      prdata_q <= rdata;
    end
  end

  // one driver for the whole response; zero wait states, so pready never drops
  assign unmapped_err = access_phase && !(sel_wait || sel_async);
  assign apb_rsp      = '{prdata: prdata_q, pready: 1'b1, pslverr: unmapped_err};

  always_comb begin
    next_wait = '0;
    case (access_area)
      3'h6: begin
        if (mpx_area_enable[2]) next_wait = mpx_code(area6_first_wait);
        else if (burst_rom && burst_later) next_wait = pitch_code(area6_burst_pitch);
        else next_wait = first_code(area6_first_wait);
      end
      3'h5: begin
        if (mpx_area_enable[1]) next_wait = mpx_code(area5_first_wait);
        else if (burst_rom && burst_later) next_wait = pitch_code(area5_burst_pitch);
        else next_wait = first_code(area5_first_wait);
      end
      3'h4: begin
        if (mpx_area_enable[0]) next_wait = mpx_code(area4_first_wait);
        else next_wait = first_code(area4_first_wait);
      end
      default: next_wait = '0;
    endcase
  end

  // registered so the wait counter sees a stable figure; ready hold-off is up to memory
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_sel    <= '0;
      ready_async <= 1'b0;
    end else begin
      wait_sel    <= next_wait;
      ready_async <= ready_async_enable;
    end
  end

  reset_value_a: assert property (@(posedge clk) !rst_n |=>
    area_wait_state_control == 32'hfffeefff) else $error("bad reset value");
  keep_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!manual_rst_n || standby) && !bus_wr |=> $stable(area_wait_state_control))
    else $error("register lost value");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    area_wait_state_control[16] == 1'b0 && area_wait_state_control[12] == 1'b0)
    else $error("reserved bit set");
  write_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && sel_wait |=> area_wait_state_control == ($past(apb_req.pwdata) & 32'hfffeefff))
    else $error("write not stored");
  a6_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_area == 3'h6 && !mpx_area_enable[2] && !burst_later && area6_first_wait == 3'h4
    |=> wait_sel.waits == 4'h6 && wait_sel.ready_enable) else $error("area6 wait code");
  a6_pitch_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_area == 3'h6 && !mpx_area_enable[2] && burst_rom && burst_later
    |=> wait_sel.waits == {1'b0, $past(area6_burst_pitch)}) else $error("area6 pitch");
  a5_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_area == 3'h5 && !mpx_area_enable[1] && !burst_later && area5_first_wait == 3'h0
    |=> !wait_sel.ready_enable && wait_sel.waits == 4'h0) else $error("area5 ready");
  a5_pitch_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_area == 3'h5 && !mpx_area_enable[1] && burst_rom && burst_later
    |=> wait_sel.waits == {1'b0, $past(area5_burst_pitch)}) else $error("area5 pitch");
  a4_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_area == 3'h4 && !mpx_area_enable[0] && area4_first_wait == 3'h7
    |=> wait_sel.waits == 4'hf) else $error("area4 wait code");
  no_burst_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_area == 3'h6 && !mpx_area_enable[2] && !burst_rom && area6_first_wait == 3'h6
    |=> wait_sel.waits == 4'hc) else $error("pitch used outside burst");
  mpx_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_area == 3'h4 && mpx_area_enable[0] |=> wait_sel.ready_enable)
    else $error("mpx coding not used");
  async_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && sel_async |=> ##1 ready_async == $past(apb_req.pwdata[0], 2))
    else $error("async enable not applied");

  // bus phases named once so read and write checks share one view of the handshake
  sequence apb_setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence apb_read_setup_s;
    apb_setup_s ##0 !apb_req.pwrite;
  endsequence
  sequence apb_access_s;
    apb_req.psel && apb_req.penable;
  endsequence
  sequence wait_write_s;
    apb_access_s ##0 (apb_req.pwrite && sel_wait);
  endsequence
  sequence async_write_s;
    apb_access_s ##0 (apb_req.pwrite && sel_async);
  endsequence

  // lookup paths per area; mpx outranks pitch, pitch outranks first wait
  sequence a6_first_s;
    access_area == 3'h6 && !mpx_area_enable[2] && !(burst_rom && burst_later);
  endsequence
  sequence a6_pitch_s;
    access_area == 3'h6 && !mpx_area_enable[2] && burst_rom && burst_later;
  endsequence
  sequence a5_first_s;
    access_area == 3'h5 && !mpx_area_enable[1] && !(burst_rom && burst_later);
  endsequence
  sequence a5_pitch_s;
    access_area == 3'h5 && !mpx_area_enable[1] && burst_rom && burst_later;
  endsequence
  sequence a4_first_s;
    access_area == 3'h4 && !mpx_area_enable[0];
  endsequence
  sequence mpx6_s;
    access_area == 3'h6 && mpx_area_enable[2];
  endsequence
  sequence mpx5_s;
    access_area == 3'h5 && mpx_area_enable[1];
  endsequence

  read_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_read_setup_s ##0 sel_wait
    |=> apb_rsp.prdata[16] == 1'b0 && apb_rsp.prdata[12] == 1'b0)
    else $error("reserved bit read as one");
  read_async_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_read_setup_s ##0 sel_async
    |=> apb_rsp.prdata == {31'h0, $past(ready_async_enable)})
    else $error("async enable read back wrong");
  read_unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_read_setup_s ##0 (!sel_wait && !sel_async)
    |=> apb_rsp.prdata == 32'h0)
    else $error("unmapped read not zero");
  prdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(apb_req.psel && !apb_req.penable && !apb_req.pwrite)
    |=> $stable(apb_rsp.prdata))
    else $error("read data moved outside setup");
  zero_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_access_s
    |-> apb_rsp.pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_access_s ##0 (!sel_wait && !sel_async)
    |-> apb_rsp.pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_access_s ##0 (sel_wait || sel_async)
    |-> !apb_rsp.pslverr)
    else $error("mapped access flagged as error");
  err_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(apb_req.psel && apb_req.penable)
    |-> !apb_rsp.pslverr)
    else $error("error outside access phase");

  // only a bus write may move either register
  wait_only_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus_wr && sel_wait)
    |=> $stable(area_wait_state_control))
    else $error("wait register changed without write");
  async_only_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus_wr && sel_async)
    |=> $stable(ready_async_enable))
    else $error("async enable changed without write");
  async_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    async_write_s
    |=> ready_async_enable == $past(apb_req.pwdata[0]))
    else $error("async enable write lost");
  wait_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    wait_write_s
    |=> area_wait_state_control[16] == 1'b0 && area_wait_state_control[12] == 1'b0)
    else $error("reserved bit stored");
  reset_outputs_a: assert property (@(posedge clk)
    !rst_n
    |=> !ready_async_enable && !ready_async && wait_sel == '0 && apb_rsp.prdata == 32'h0)
    else $error("outputs not cleared by reset");
  async_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1
    |=> ready_async == $past(ready_async_enable))
    else $error("ready async does not follow enable");

  a6_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    a6_first_s ##0 area6_first_wait == 3'h0
    |=> wait_sel.waits == 4'h0 && !wait_sel.ready_enable)
    else $error("area6 code zero wrong");
  a6_max_a: assert property (@(posedge clk) disable iff (!rst_n)
    a6_first_s ##0 area6_first_wait == 3'h7
    |=> wait_sel.waits == 4'hf && wait_sel.ready_enable)
    else $error("area6 code seven wrong");
  a6_pitch_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    a6_pitch_s ##0 area6_burst_pitch == 3'h0
    |=> wait_sel.waits == 4'h0 && !wait_sel.ready_enable)
    else $error("area6 pitch zero wrong");
  a5_nine_a: assert property (@(posedge clk) disable iff (!rst_n)
    a5_first_s ##0 area5_first_wait == 3'h5
    |=> wait_sel.waits == 4'h9 && wait_sel.ready_enable)
    else $error("area5 code five wrong");
  a5_twelve_a: assert property (@(posedge clk) disable iff (!rst_n)
    a5_first_s ##0 area5_first_wait == 3'h6
    |=> wait_sel.waits == 4'hc && wait_sel.ready_enable)
    else $error("area5 code six wrong");
  a5_pitch_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    a5_pitch_s ##0 area5_burst_pitch != 3'h0
    |=> wait_sel.ready_enable)
    else $error("area5 pitch ready off");
  a4_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    a4_first_s ##0 area4_first_wait == 3'h0
    |=> wait_sel.waits == 4'h0 && !wait_sel.ready_enable)
    else $error("area4 code zero wrong");
  a4_three_a: assert property (@(posedge clk) disable iff (!rst_n)
    a4_first_s ##0 area4_first_wait == 3'h3
    |=> wait_sel.waits == 4'h3 && wait_sel.ready_enable)
    else $error("area4 code three wrong");
  a4_no_pitch_a: assert property (@(posedge clk) disable iff (!rst_n)
    a4_first_s ##0 (burst_rom && burst_later && area4_first_wait == 3'h5)
    |=> wait_sel.waits == 4'h9)
    else $error("area4 used a pitch");
  a5_no_burst_a: assert property (@(posedge clk) disable iff (!rst_n)
    a5_first_s ##0 (!burst_rom && area5_first_wait == 3'h4)
    |=> wait_sel.waits == 4'h6)
    else $error("area5 pitch outside burst");

  // mpx areas count one address cycle on top of the code
  mpx6_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    mpx6_s
    |=> wait_sel.waits == {1'b0, $past(area6_first_wait)} + 4'h1 && wait_sel.ready_enable)
    else $error("area6 mpx coding wrong");
  mpx5_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    mpx5_s
    |=> wait_sel.waits == {1'b0, $past(area5_first_wait)} + 4'h1 && wait_sel.ready_enable)
    else $error("area5 mpx coding wrong");

endmodule : awsc_area_wait_state_control

// file: verilog/awsc_pkg.sv
package awsc_pkg;

  localparam logic [11:0] AWSC_REG_OFFSET   = 12'h000;
  localparam logic [11:0] AWSC_ASYNC_OFFSET = 12'h004;
  localparam logic [31:0] AWSC_RESET_VALUE  = 32'hfffeefff;
  localparam logic [31:0] AWSC_WRITE_MASK   = 32'hfffeefff;
  localparam int          AWSC_A6W_LSB      = 29;
  localparam int          AWSC_A6B_LSB      = 26;
  localparam int          AWSC_A5W_LSB      = 23;
  localparam int          AWSC_A5B_LSB      = 20;
  localparam int          AWSC_A4W_LSB      = 17;
  localparam logic [2:0]  AWSC_A3_LSB_IDX   = 3'h0;

  typedef struct packed {
    logic [3:0] waits;
    logic       ready_enable;
  } awsc_wait_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } awsc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } awsc_apb_rsp_t;

endpackage : awsc_pkg

// file: sim/awsc_mem_model.sv
`timescale 1ns/10ps
module awsc_mem_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [2:0] area,
  input  wire logic [1:0] kind,
  output logic [2:0]      access_area,
  output logic            burst_rom,
  output logic            burst_later,
  output logic [2:0]      mpx_area_enable
);
  // kind: 0 first beat, 1 later burst beat, 2 later beat without burst rom, 3 multiplexed
  initial {access_area, burst_rom, burst_later, mpx_area_enable} = 8'h0;
  always @(posedge clk) begin
    if (start) begin
      access_area     <= area;
      burst_rom       <= kind != 2'h2;
      burst_later     <= kind != 2'h0;
      mpx_area_enable <= (kind == 2'h3) ? 3'h1 << (area - 3'h4) : 3'h0;
    end
  end
endmodule : awsc_mem_model

// file: sim/awsc_area_wait_state_control_tb.sv
`timescale 1ns/10ps
module awsc_area_wait_state_control_tb;
  import awsc_pkg::*;
  logic          clk = 0, rst_n = 0, mrst_n = 1, stby = 0, start = 0, br, bl, ra;
  logic [2:0]    area = 3'h6, ar, multiplexed_bus_interface;
  logic [1:0]    kind = 2'h0, lk = 2'h0;
  awsc_apb_req_t rq = '0;
  awsc_apb_rsp_t rs;
  awsc_wait_t    ws, ew;
  logic [32:0]   qr[$];
  awsc_wait_t    qw[$];
  logic [31:0]   v;
  logic [3:0]    tbl[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'hc, 4'hf};
  int            errors = 0, n_checks = 0, seed = 87141;
  always #5 clk = ~clk;
  awsc_area_wait_state_control awsc_area_wait_state_control_inst (.clk(clk), .rst_n(rst_n),
    .manual_rst_n(mrst_n), .standby(stby), .apb_req(rq), .apb_rsp(rs), .access_area(ar),
    .burst_rom(br), .burst_later(bl), .mpx_area_enable(multiplexed_bus_interface), .wait_sel(ws), .ready_async(ra));
  awsc_mem_model awsc_mem_model_inst (.clk(clk), .start(start), .area(area), .kind(kind),
    .access_area(ar), .burst_rom(br), .burst_later(bl), .mpx_area_enable(multiplexed_bus_interface));
  task automatic test_done();
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
    n_checks++;
    if (e !== s) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // one idle cycle after each transfer keeps the driver from assigning psel twice in a step
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int i;
    rq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    rq.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rs.pready !== 1'b1 && i < 20);
    if (i == 20) begin
      errors++;
      test_done();
    end
    rq <= '0;
    @(posedge clk);
  endtask : apb
  task automatic look(logic [2:0] a, logic [1:0] k, awsc_wait_t e);
    qw.push_back(e);
    area <= a;
    kind <= k;
    start <= 1'b1;
    @(posedge clk);
  endtask : look
  // results land one edge after the model takes a request and are checked on the edge after that
  always @(posedge clk) begin
    lk <= {lk[0], start};
    if (rq.psel && rq.penable && rs.pready && !rq.pwrite) chk("prdata", qr.pop_front(),
      {rs.pslverr, rs.prdata});
    if (lk[1]) chk("wait_sel", {28'h0, qw.pop_front()}, {28'h0, ws});
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    qr.push_back({1'b0, AWSC_RESET_VALUE});
    apb(1'b0, AWSC_REG_OFFSET, 32'h0);
    v = $random(seed) & AWSC_WRITE_MASK;
    apb(1'b1, AWSC_REG_OFFSET, v);
    mrst_n <= 1'b0;
    stby <= 1'b1;
    repeat (3) @(posedge clk);
    mrst_n <= 1'b1;
    stby <= 1'b0;
    qr.push_back({1'b0, v & AWSC_WRITE_MASK});
    apb(1'b0, AWSC_REG_OFFSET, 32'h0);
    for (int c = 0; c < 8; c++) begin
      v = ($random(seed) & 32'h0000efff) | {{5{c[2:0]}}, 17'h0};
      apb(1'b1, AWSC_REG_OFFSET, v);
      for (int a = 4; a < 7; a++) for (int k = 0; k < 4; k++) begin
        ew.waits = (k == 3) ? 4'(c + 1) : (k == 1 && a > 4) ? 4'(c) : tbl[c];
        ew.ready_enable = (k == 3) || (c != 0);
        look(a[2:0], k[1:0], ew);
      end
      start <= 1'b0;
      repeat (3) @(posedge clk);
    end
    qr.push_back(33'h0);
    apb(1'b0, AWSC_ASYNC_OFFSET, 32'h0);
    apb(1'b1, AWSC_ASYNC_OFFSET, 32'h1);
    qr.push_back(33'h1);
    apb(1'b0, AWSC_ASYNC_OFFSET, 32'h0);
    qr.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h008, 32'h0);
    chk("ready_async", 33'h1, {32'h0, ra});
    test_done();
  end
endmodule : awsc_area_wait_state_control_tb
